// *** rtl/host_port_regs.vh ***
// Offsets, fields and timing counts of the indirect host register port
// Included by the top-level design file of the port only
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define OFS_DATA_BYTE_0        3'h0
`define OFS_DATA_BYTE_1        3'h1
`define OFS_DATA_BYTE_2        3'h2
`define OFS_DATA_BYTE_3        3'h3
`define OFS_SLEEP_PROGRAM      3'h4
`define OFS_SYNC_COMMAND       3'h5
`define OFS_ADDRESS_LOW        3'h6
`define OFS_ADDRESS_HIGH       3'h7
`define UAR_WRINC_BIT          7
`define UAR_RDINC_BIT          6
`define UAR_ADDR_MSB           3
`define SYNC_BEAM_BIT          6
`define SYNC_HOP_BIT           5
`define SYNC_START_BIT         4
`define SLEEP_RESET            8'h00
`define ADDR_RESET             8'h00
`define DATA_RESET             32'h0000_0000
`define ACCESS_CYCLES          2'h2
`endif

// *** rtl/pin_sync.v ***
// Two-flop synchroniser for one pin
// Assumes the pin is asynchronous to clock
`timescale 1ns/10ps
module pin_sync (
    input  wire clock,
    input  wire nrst,
    input  wire enable,
    input  wire pin,
    output wire level
);
    reg meta_ff;
    reg level_ff;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_ff  <= 1'b0;
            level_ff <= 1'b0;
        end else if (enable) begin
            meta_ff  <= pin;
            level_ff <= meta_ff;
        end
    end

    assign level = level_ff;
endmodule // pin_sync

// *** rtl/sync_bus.v ***
// Two-flop synchroniser for a bus of pins
// Assumes each bit is quasi-static while sampled
`timescale 1ns/10ps
module sync_bus #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire             enable,
    input  wire [WIDTH-1:0] pins,
    output wire [WIDTH-1:0] levels
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] level_ff;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_ff  <= {WIDTH{1'b0}};
            level_ff <= {WIDTH{1'b0}};
        end else if (enable) begin
            meta_ff  <= pins;
            level_ff <= meta_ff;
        end
    end

    assign levels = level_ff;
endmodule // sync_bus

// *** rtl/indirect_host_register_port.v ***
// Indirect host register port: 8 external registers reaching a 12-bit/32-bit space
// Assumes an async host bus on pins, internal space answering in two cycles
//
// Functional notes
// R01: 3-bit address, 8-bit data, indirect internal access
// R02: Bytes 0..3 form word, byte 0 LSB
// R03: Byte 0 write triggers internal write
// R04: Byte 0 read launches read, captures word
// R05: Host reads byte 0 first after address
// R06: Sleep and sync act at once
// R07: Program bits 7..4, sleep 3..0, start clears
// R08: Sync write-only: beam, hop, start per channel
// R09: Internal address 12 bits, data 32 bits
// R10: Upper register bits 3..0 give address 11..8
// R11: Bit 6 increments address after reads
// R12: Bit 7 increments address after writes
// R13: Both bits: increment after every access
// R14: Lower register gives address bits 7..0
// R15: Internal access lasts two clock cycles
// R16: Host loads both address registers first
// R17: 16-bit location: write byte 1, then 0
// R18: Mode strap picks strobe protocol
// R19: Separate strobes: ready low until done
// R20: Data strobe: ack low until strobe released
// R21: Ready/ack output is open drain
// R22: Many accesses while chip select low
// R23: Host sets program bit before memory loading
// R24: Ready/ack undriven when not asserted
`timescale 1ns/10ps
`include "host_port_regs.vh"
module indirect_host_register_port (
    input  wire        clock,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire        mode_strap,
    input  wire        chip_select_n,
    input  wire        read_strobe_n,
    input  wire        write_strobe_n,
    input  wire [2:0]  ext_addr,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output wire        data_oe,
    output wire        ready_ack_out,
    output wire        ready_ack_oe,
    output reg  [11:0] internal_addr,
    output reg  [31:0] internal_wdata,
    input  wire [31:0] internal_rdata,
    output reg         internal_wr,
    output reg         internal_rd,
    input  wire [3:0]  start_sync_done,
    output wire [3:0]  program_enable,
    output wire [3:0]  channel_sleep,
    output reg  [3:0]  beam_sync,
    output reg  [3:0]  hop_sync,
    output reg  [3:0]  start_sync
);
    // Protocol states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ACC  = 4'b0010;
    localparam [3:0] ST_DONE = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;

    wire        cs_act;
    wire        rd_act;
    wire        wr_act;
    wire        cs_n_s;
    wire        rd_n_s;
    wire        wr_n_s;
    wire        mode_s;
    wire [2:0]  addr_s;
    wire [7:0]  din_s;

    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg         mode_ff;
    reg         is_wr_ff;
    reg  [2:0]  reg_sel_ff;
    reg  [1:0]  cnt_ff;
    reg  [7:0]  upper_address_reg;
    reg  [7:0]  lower_address_reg;
    reg  [31:0] data_word_ff;
    reg  [7:0]  sleep_prog_ff;
    reg  [7:0]  nxt_dout;

    wire [11:0] internal_addr_bit;
    wire [11:0] next_addr;
    wire        strobe_on;
    wire        is_wr_now;
    wire        indirect;
    wire        acc_end;

    // Active-low pins synchronised inverted, so reset reads as idle
    pin_sync u_cs (
        .clock  (clock),
        .nrst   (nrst),
        .enable (clk_en),
        .pin    (~chip_select_n),
        .level  (cs_act)
    );

    pin_sync u_mode (
        .clock  (clock),
        .nrst   (nrst),
        .enable (clk_en),
        .pin    (mode_strap),
        .level  (mode_s)
    );

    sync_bus #(.WIDTH(13)) u_bus (
        .clock  (clock),
        .nrst   (nrst),
        .enable (clk_en),
        .pins   ({~read_strobe_n, ~write_strobe_n, ext_addr, data_in}),
        .levels ({rd_act, wr_act, addr_s, din_s})
    );

    assign cs_n_s = ~cs_act;
    assign rd_n_s = ~rd_act;
    assign wr_n_s = ~wr_act;

    // Strobe decode: mode 0 uses separate strobes, mode 1 data strobe plus direction
    assign strobe_on = !cs_n_s && (mode_ff ? !rd_n_s : (!rd_n_s || !wr_n_s)); // see R18
    assign is_wr_now = mode_ff ? !wr_n_s : !wr_n_s; // see R18
    assign indirect  = (reg_sel_ff == `OFS_DATA_BYTE_0); // see R03 R04
    assign acc_end   = (state_ff == ST_ACC) && (cnt_ff == 2'h1);

    // Internal address from both address registers
    assign internal_addr_bit = {upper_address_reg[`UAR_ADDR_MSB:0],
                                lower_address_reg}; // see R09 R10 R14
    assign next_addr = internal_addr_bit + 12'h001;

    assign program_enable = sleep_prog_ff[7:4]; // see R07 R23
    assign channel_sleep  = sleep_prog_ff[3:0]; // see R07

    // Open-drain ready/ack: drive low only, else release
    assign ready_ack_out = 1'b0; // see R21
    assign ready_ack_oe  = mode_ff ? (state_ff == ST_HOLD) // see R20 R24
                                   : (state_ff == ST_ACC); // see R19 R24
    assign data_oe = !cs_n_s && !rd_n_s && !(mode_ff && !wr_n_s);

    always @* begin
        case (state_ff)
            ST_IDLE: nxt_state = strobe_on ? ST_ACC : ST_IDLE; // see R22
            ST_ACC:  nxt_state = acc_end ? (mode_ff ? ST_HOLD : ST_DONE) : ST_ACC;
            ST_DONE: nxt_state = strobe_on ? ST_DONE : ST_IDLE;
            ST_HOLD: nxt_state = strobe_on ? ST_HOLD : ST_IDLE; // see R20
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @* begin
        case (addr_s)
            `OFS_DATA_BYTE_0:   nxt_dout = internal_rdata[7:0]; // see R04
            `OFS_DATA_BYTE_1:   nxt_dout = data_word_ff[15:8]; // see R02
            `OFS_DATA_BYTE_2:   nxt_dout = data_word_ff[23:16];
            `OFS_DATA_BYTE_3:   nxt_dout = data_word_ff[31:24];
            `OFS_SLEEP_PROGRAM: nxt_dout = sleep_prog_ff; // see R06
            `OFS_ADDRESS_LOW:   nxt_dout = lower_address_reg;
            `OFS_ADDRESS_HIGH:  nxt_dout = upper_address_reg;
            default:            nxt_dout = 8'h00; // see R08
        endcase
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff          <= ST_IDLE;
            mode_ff           <= 1'b0;
            is_wr_ff          <= 1'b0;
            reg_sel_ff        <= 3'h0;
            cnt_ff            <= 2'h0;
            upper_address_reg <= `ADDR_RESET;
            lower_address_reg <= `ADDR_RESET;
            data_word_ff      <= `DATA_RESET;
            sleep_prog_ff     <= `SLEEP_RESET;
            data_out          <= 8'h00;
            internal_addr     <= 12'h000;
            internal_wdata    <= `DATA_RESET;
            internal_wr       <= 1'b0;
            internal_rd       <= 1'b0;
            beam_sync         <= 4'h0;
            hop_sync          <= 4'h0;
            start_sync        <= 4'h0;
        end else if (clk_en) begin
            state_ff   <= nxt_state;
            beam_sync  <= 4'h0;
            hop_sync   <= 4'h0;
            start_sync <= 4'h0;
            internal_rd <= 1'b0;
            internal_wr <= 1'b0;
            // Strap caught only while idle with no chip select
            if (state_ff == ST_IDLE && cs_n_s) begin
                mode_ff <= mode_s; // see R18
            end
            // Start sync clears sleep bits; a host write in the same cycle is applied after
            sleep_prog_ff[3:0] <= sleep_prog_ff[3:0] & ~start_sync_done; // see R07
            if (state_ff == ST_IDLE && strobe_on) begin
                is_wr_ff   <= is_wr_now;
                reg_sel_ff <= addr_s; // see R01
                cnt_ff     <= `ACCESS_CYCLES; // see R15
                if (is_wr_now) begin
                    case (addr_s)
                        `OFS_DATA_BYTE_0: begin
                            internal_wdata <= {data_word_ff[31:8], din_s}; // see R03
                            data_word_ff[7:0] <= din_s;
                            internal_addr  <= internal_addr_bit;
                            internal_wr    <= 1'b1;
                        end
                        `OFS_DATA_BYTE_1:   data_word_ff[15:8]  <= din_s; // see R17
                        `OFS_DATA_BYTE_2:   data_word_ff[23:16] <= din_s;
                        `OFS_DATA_BYTE_3:   data_word_ff[31:24] <= din_s;
                        `OFS_SLEEP_PROGRAM: sleep_prog_ff <= din_s; // see R06
                        `OFS_SYNC_COMMAND: begin
                            beam_sync  <= din_s[`SYNC_BEAM_BIT]  ? din_s[3:0] : 4'h0; // see R08
                            hop_sync   <= din_s[`SYNC_HOP_BIT]   ? din_s[3:0] : 4'h0;
                            start_sync <= din_s[`SYNC_START_BIT] ? din_s[3:0] : 4'h0;
                        end
                        `OFS_ADDRESS_LOW:   lower_address_reg <= din_s; // see R14 R16
                        `OFS_ADDRESS_HIGH:  upper_address_reg <= din_s; // see R10 R16
                        default:            data_word_ff <= data_word_ff;
                    endcase
                end else begin
                    if (addr_s == `OFS_DATA_BYTE_0) begin
                        internal_addr <= internal_addr_bit;
                        internal_rd   <= 1'b1; // see R04
                    end else begin
                        data_out <= nxt_dout; // see R05
                    end
                end
            end else if (state_ff == ST_ACC) begin
                cnt_ff <= cnt_ff - 2'h1;
                if (acc_end && indirect) begin
                    if (!is_wr_ff) begin
                        data_word_ff <= internal_rdata; // see R04
                        data_out     <= internal_rdata[7:0];
                    end
                    if ((is_wr_ff && upper_address_reg[`UAR_WRINC_BIT]) || // see R12 R13
                        (!is_wr_ff && upper_address_reg[`UAR_RDINC_BIT])) begin // see R11 R13
                        upper_address_reg[`UAR_ADDR_MSB:0] <= next_addr[11:8];
                        lower_address_reg <= next_addr[7:0];
                    end
                end
            end
        end
    end
endmodule // indirect_host_register_port

// *** verification/port_asserts.sv ***
// Pin and internal strobe assertions of the indirect host register port
// Bound to every port instance; sees only its ports
`timescale 1ns/10ps
module port_asserts (
    input wire        clock,
    input wire        nrst,
    input wire        clk_en,
    input wire        mode_strap,
    input wire        chip_select_n,
    input wire        read_strobe_n,
    input wire        ready_ack_out,
    input wire        ready_ack_oe,
    input wire [11:0] internal_addr,
    input wire        internal_wr,
    input wire        internal_rd,
    input wire [3:0]  start_sync_done,
    input wire [3:0]  channel_sleep,
    input wire [3:0]  beam_sync,
    input wire [3:0]  hop_sync,
    input wire [3:0]  start_sync
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_acc; internal_wr || internal_rd; endsequence
    sequence s_idle; chip_select_n [*4]; endsequence
    property p_one_kind; !(internal_wr && internal_rd); endproperty
    a_one_kind: assert property (p_one_kind) else $error("read and write together");
    property p_wr_pulse; internal_wr |=> !internal_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_pulse; internal_rd |=> !internal_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_addr_step;
        s_acc |=> ##1 (internal_addr == $past(internal_addr, 2)
            || internal_addr == $past(internal_addr, 2) + 12'h001);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("bad address step");
    property p_rdy_acc; (internal_wr || internal_rd) && !mode_strap |-> ready_ack_oe; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("ready not low in access");
    property p_rdy_len; !mode_strap && $rose(ready_ack_oe) |=> ready_ack_oe ##1 !ready_ack_oe;
    endproperty
    a_rdy_len: assert property (p_rdy_len) else $error("ready length");
    property p_ack_late;
        s_acc ##0 mode_strap |-> !ready_ack_oe ##1 !ready_ack_oe ##1 ready_ack_oe;
    endproperty
    a_ack_late: assert property (p_ack_late) else $error("ack not at completion");
    property p_ack_hold; mode_strap && ready_ack_oe && !read_strobe_n |=> ready_ack_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    property p_od; ready_ack_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("ready line driven high");
    property p_sync_pulse;
        (beam_sync | hop_sync | start_sync) != 4'h0 |=>
            (beam_sync | hop_sync | start_sync) == 4'h0;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
    property p_start_clr;
        s_idle ##0 (clk_en && start_sync_done != 4'h0) |=>
            (channel_sleep & $past(start_sync_done)) == 4'h0;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("sleep not cleared");
endmodule // port_asserts
bind indirect_host_register_port port_asserts u_port_asserts (.clock(clock), .nrst(nrst),
    .clk_en(clk_en),
    .mode_strap(mode_strap), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .ready_ack_out(ready_ack_out), .ready_ack_oe(ready_ack_oe), .internal_addr(internal_addr),
    .internal_wr(internal_wr), .internal_rd(internal_rd), .start_sync_done(start_sync_done),
    .channel_sleep(channel_sleep), .beam_sync(beam_sync), .hop_sync(hop_sync),
    .start_sync(start_sync));

// *** verification/mem_model.sv ***
// Internal register and memory space behind the port
// Assumes one-cycle access strobes on the port clock
`timescale 1ns/10ps
module mem_model (
    input  wire         clock,
    input  wire  [11:0] internal_addr,
    input  wire  [31:0] internal_wdata,
    input  wire         internal_wr,
    input  wire         internal_rd,
    output logic [31:0] internal_rdata
);
    logic [31:0] mem [0:4095];
    logic [31:0] junk_ff = 32'h1234_5678;
    logic        rd_ff = 1'b0;
    always @(posedge clock) begin
        rd_ff <= internal_rd;
        junk_ff <= {junk_ff[30:0], ~junk_ff[31]};
        if (internal_wr) mem[internal_addr] <= internal_wdata;
    end
    // Word valid only through the two-cycle read
    assign internal_rdata = (internal_rd || rd_ff) ? mem[internal_addr] : junk_ff;
endmodule // mem_model

// *** verification/indirect_host_register_port_bench.sv ***
// Self-checking bench of the indirect host register port
// Assumes the mem_model partner and the bound checker
`timescale 1ns/10ps
module indirect_host_register_port_bench;
    logic        clock, nrst, clk_en, mode_strap, chip_select_n, read_strobe_n, write_strobe_n;
    logic        data_oe, ready_ack_out, ready_ack_oe, internal_wr, internal_rd;
    logic [2:0]  ext_addr;
    logic [7:0]  data_in, data_out, q;
    logic [11:0] internal_addr, a, got;
    logic [31:0] internal_wdata, internal_rdata, w, w2, rd_word;
    logic [3:0]  start_sync_done, program_enable, channel_sleep, beam_sync, hop_sync, start_sync;
    int          miscompares, samples_checked, n, m, k, b;
    indirect_host_register_port u_indirect_host_register_port (.clock(clock), .nrst(nrst),
        .clk_en(clk_en), .mode_strap(mode_strap), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ext_addr(ext_addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready_ack_out(ready_ack_out),
        .ready_ack_oe(ready_ack_oe), .internal_addr(internal_addr),
        .internal_wdata(internal_wdata), .internal_rdata(internal_rdata),
        .internal_wr(internal_wr), .internal_rd(internal_rd), .start_sync_done(start_sync_done),
        .program_enable(program_enable), .channel_sleep(channel_sleep), .beam_sync(beam_sync),
        .hop_sync(hop_sync), .start_sync(start_sync));
    mem_model u_mem_model (.clock(clock), .internal_addr(internal_addr),
        .internal_wdata(internal_wdata), .internal_wr(internal_wr), .internal_rd(internal_rd),
        .internal_rdata(internal_rdata));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if ((beam_sync | hop_sync | start_sync) != 4'h0) got <= {beam_sync, hop_sync, start_sync};
    end
    function automatic logic [11:0] sync_exp(input int kind, input logic [3:0] sel);
        return {8'h00, sel} << (4 * (kind - 4));
    endfunction
    task automatic check(input logic [31:0] act, input logic [31:0] exp_v, input string what);
        samples_checked++;
        if (act !== exp_v) begin
            miscompares++;
            $display("BAD %0t %s got %h want %h", $time, what, act, exp_v);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_oe(input logic v);
        n = 0;
        while (ready_ack_oe !== v) begin
            if (n++ == 60) begin
                miscompares++;
                $display("BAD %0t handshake timeout", $time);
                tally_and_finish;
            end
            @(posedge clock);
            #1;
        end
    endtask
    task automatic acc(input logic wr, input logic [2:0] ad, input logic [7:0] d);
        @(posedge clock);
        chip_select_n <= 1'b0;
        ext_addr <= ad;
        data_in <= d;
        write_strobe_n <= mode_strap ? !wr : 1'b1;
        @(posedge clock);
        if (mode_strap || !wr) read_strobe_n <= 1'b0;
        else write_strobe_n <= 1'b0;
        wait_oe(1'b1);
        if (!mode_strap) wait_oe(1'b0);
        repeat (2) @(posedge clock);
        q = data_out;
        check(32'(data_oe), 32'(!wr), "data enable");
        read_strobe_n <= 1'b1;
        if (!mode_strap) write_strobe_n <= 1'b1;
        wait_oe(1'b0);
        repeat (4) @(posedge clock);
    endtask
    task automatic set_addr(input logic [11:0] ad, input logic [1:0] inc);
        acc(1'b1, 3'h7, {inc, 2'b00, ad[11:8]});
        acc(1'b1, 3'h6, ad[7:0]);
    endtask
    task automatic put_word(input logic [31:0] v);
        for (k = 3; k >= 0; k--) acc(1'b1, 3'(k), v[8*k +: 8]);
    endtask
    task automatic get_word;
        for (k = 0; k < 4; k++) begin
            b = (k == 0) ? 0 : 4 - k;
            acc(1'b0, 3'(b), 8'h00);
            rd_word[8*b +: 8] = q;
        end
    endtask
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        mode_strap = 1'b0;
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        ext_addr = 3'h0;
        data_in = 8'h00;
        start_sync_done = 4'h0;
        got = 12'h000;
        miscompares = 0;
        samples_checked = 0;
        n = $urandom(32'hade7);
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        for (m = 0; m < 2; m++) begin
            @(posedge clock);
            chip_select_n <= 1'b1;
            mode_strap <= m[0];
            repeat (6) @(posedge clock);
            a = 12'($urandom);
            w = $urandom;
            w2 = $urandom;
            set_addr(a, 2'b11);
            put_word(w);
            put_word(w2);
            check(u_mem_model.mem[a], w, "word write");
            check(u_mem_model.mem[a + 12'h001], w2, "write inc");
            set_addr(a, 2'b11);
            get_word;
            check(rd_word, w, "word read");
            get_word;
            check(rd_word, w2, "read inc");
            a = 12'hfff;
            w = $urandom;
            set_addr(a, 2'b00);
            acc(1'b1, 3'h1, w[15:8]);
            acc(1'b1, 3'h0, w[7:0]);
            check(32'(u_mem_model.mem[a][15:0]), 32'(w[15:0]), "half word");
            for (k = 0; k < 2; k++) begin
                acc(1'b0, 3'h0, 8'h00);
                check(32'(q), 32'(w[7:0]), "no inc read");
            end
            acc(1'b1, 3'h4, w[23:16]);
            acc(1'b0, 3'h4, 8'h00);
            check(32'(q), 32'(w[23:16]), "sleep readback");
            @(posedge clock);
            chip_select_n <= 1'b1;
            repeat (6) @(posedge clock);
            clk_en <= 1'b0;
            start_sync_done <= 4'h1;
            repeat (2) @(posedge clock);
            check(32'(channel_sleep), 32'(w[19:16]), "frozen sleep");
            clk_en <= 1'b1;
            @(posedge clock);
            start_sync_done <= 4'h0;
            repeat (2) @(posedge clock);
            check(32'({program_enable, channel_sleep}), 32'(w[23:16] & 8'hfe),
                  "start clear");
            for (k = 4; k < 7; k++) begin
                got = 12'h000;
                w = $urandom;
                acc(1'b1, 3'h5, {1'b0, 3'(1 << (k - 4)), w[3:0] | 4'h4});
                check(32'(got), 32'(sync_exp(k, w[3:0] | 4'h4)), "sync pulse");
            end
            acc(1'b0, 3'h5, 8'h00);
            check(32'(q), 32'h0000_0000, "sync read");
            $display("mode %0d done", m);
        end
        tally_and_finish;
    end
endmodule // indirect_host_register_port_bench
